// >>> include/fan_supervisor_regs.svh
// register map, field positions and limits of the fan motor supervisor
`ifndef FAN_SUPERVISOR_REGS_SVH
`define FAN_SUPERVISOR_REGS_SVH

// register byte offsets
`define REG_OPCMD      8'h00
`define REG_SPEED_CMD  8'h04
`define REG_STATUS     8'h08
`define REG_IRQ_STAT   8'h0c
`define REG_IRQ_MASK   8'h10
`define REG_BUS_VOLT   8'h14
`define REG_CUR_U      8'h18
`define REG_CUR_V      8'h1c
`define REG_CUR_W      8'h20
`define REG_SPEED_MEAS 8'h24

// operating command values
`define OPCMD_STOP     2'h0
`define OPCMD_RUN      2'h1
`define OPCMD_ERR_RST  2'h3

// fault and interrupt bit positions
`define FLT_SW_OC      0
`define FLT_OV         1
`define FLT_UV         2
`define FLT_OSPD       3
`define FLT_HW_OC      4
`define FLT_W          5

// status register fields
`define STAT_STATE_LSB 0
`define STAT_HWTRIP    4
`define STAT_OPCMD_LSB 8

// reset values
`define RST_OPCMD      2'h0
`define RST_SPEED      16'h0000
`define RST_MASK       5'h00

// timing
`define CLK_HZ         40000000
`define CTRL_PERIOD_US 125
`define CARRIERS_PER_CTRL 2

// scaling: 12-bit codes, volts in 0.1 V, currents in mA
`define ADC_FS         4095
`define VBUS_FS_DV     6865
`define I_SPAN_MA      100000
`define I_OFS_MA       50000

// protection limits
`define OC_LIMIT_MA    3000
`define OV_LIMIT_DV    4200
`define UV_LIMIT_DV    0
`define OSPD_LIMIT_RADS 272

`endif

// >>> include/fan_supervisor_pkg.sv
// types shared by the fan motor supervisor files
package fan_supervisor_pkg;

	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_RUN = 3'b010,
		ST_ERROR = 3'b100
	} run_state_e;

	// raw converter codes, one per channel
	typedef struct packed {
		logic [11:0] bus_voltage_channel;
		logic [11:0] phase_u_current_channel;
		logic [11:0] phase_v_current_channel;
		logic [11:0] phase_w_current_channel;
	} adc_sample_s;

	// phase voltage commands in 0.1 V, signed
	typedef struct packed {
		logic signed [15:0] u;
		logic signed [15:0] v;
		logic signed [15:0] w;
	} phase_vcmd_s;

	// six gate drives, index 0 = u, 1 = v, 2 = w
	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} gate_s;

	typedef logic [2:0][15:0] cmp_t;

endpackage

// >>> design/pwm_triangle_gen.sv
// triangle carrier, control period tick and three phase compares
`timescale 1ns/1ps
`include "fan_supervisor_regs.svh"

module pwm_triangle_gen #(
	parameter logic [15:0] HALF = 16'h04e2
) (
	input wire logic core_clk_i, // system clock
	input wire logic sys_rst_i, // async reset, high
	input wire fan_supervisor_pkg::cmp_t cmp_i, // compare levels per phase
	output logic [15:0] carrier_o, // carrier value
	output logic ctrl_tick_o, // one pulse per control period
	output logic [2:0] phase_on_o // phase above carrier
);
	import fan_supervisor_pkg::*;

	logic [15:0] cnt_r, cnt_nxt;
	logic down_r, down_nxt;
	logic [1:0] ncar_r, ncar_nxt;
	logic tick_r, tick_nxt;
	logic [2:0] on_r, on_nxt;

	// up/down count, period count and compare
	always_comb begin
		cnt_nxt = cnt_r;
		down_nxt = down_r;
		ncar_nxt = ncar_r;
		tick_nxt = 1'b0;
		if (!down_r) begin
			cnt_nxt = cnt_r + 16'h0001;
			if (cnt_r + 16'h0001 == HALF) down_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r - 16'h0001;
			if (cnt_r == 16'h0001) begin
				down_nxt = 1'b0;
				// control period spans two carrier periods
				if (ncar_r == 2'(`CARRIERS_PER_CTRL - 1)) begin
					ncar_nxt = 2'h0;
					tick_nxt = 1'b1;
				end else begin
					ncar_nxt = ncar_r + 2'h1;
				end
			end
		end
		// on while command above carrier, off below
		for (int i = 0; i < 3; i++) begin
			on_nxt[i] = cmp_i[i] > cnt_r;
		end
	end

	// register the carrier group
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= 16'h0000;
			down_r <= 1'b0;
			ncar_r <= 2'h0;
			tick_r <= 1'b0;
			on_r <= 3'h0;
		end else begin
			cnt_r <= cnt_nxt;
			down_r <= down_nxt;
			ncar_r <= ncar_nxt;
			tick_r <= tick_nxt;
			on_r <= on_nxt;
		end
	end

	assign carrier_o = cnt_r;
	assign ctrl_tick_o = tick_r;
	assign phase_on_o = on_r;

endmodule // pwm_triangle_gen

// >>> design/motor_pwm_fault_supervisor.sv
// fan motor pwm supervisor: command handling, scaling, pwm, protection
// Overview of operation
// - command changed to 1 starts running from stop, not from error
// - command changed to 0 stops motor
// - command 3 clears latched error
// - act only when command differs from last
// - bus code 0..fff is 0..686.5 V
// - current code 0..fff is -50..+50 A
// - output on while command above carrier
// - modulation = command voltage over bus voltage
// - hardware overcurrent floats all pwm pins
// - each period, phase current over 3 A stops
// - each period, bus above 420 V stops
// - each period, bus below 0 V stops
// - each period, speed over 272 rad/s stops
// - monitoring once per 125 us, two carriers
// - software stop drives six gates inactive
`timescale 1ns/1ps
`include "fan_supervisor_regs.svh"

module motor_pwm_fault_supervisor #(
	parameter int unsigned CTRL_CYCLES = `CLK_HZ / 1000000 * `CTRL_PERIOD_US
) (
	input wire logic core_clk_i, // system clock 40 MHz
	input wire logic sys_rst_i, // async reset, high
	input wire logic [7:0] reg_addr_i, // register byte address
	input wire logic [31:0] reg_wdata_i, // write data
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	output logic [31:0] reg_rdata_o, // read data, cycle after strobe
	input wire fan_supervisor_pkg::adc_sample_s adc_i, // converter codes
	input wire fan_supervisor_pkg::phase_vcmd_s vcmd_i, // phase voltage cmds
	input wire logic [15:0] speed_elec_i, // electrical speed, rad/s
	input wire logic hw_overcurrent_n_i, // external overcurrent pin, low
	output logic [15:0] speed_command_rpm_o, // speed ref to controller
	output logic running_o, // motor in running state
	output fan_supervisor_pkg::gate_s gate_o, // six gate drive levels
	output logic [5:0] gate_oe_o, // gate pin enables
	output logic irq_o // unmasked fault pending
);
	import fan_supervisor_pkg::*;

	localparam logic [15:0] HALF = 16'(CTRL_CYCLES / (2 * `CARRIERS_PER_CTRL));

	// converter code to bus voltage, 0.1 V units
	function automatic logic signed [17:0] scale_bus_dv(input logic [11:0] code);
		int t;
		t = int'(code) * `VBUS_FS_DV / `ADC_FS;
		return 18'(t);
	endfunction

	// converter code to phase current, mA units
	function automatic logic signed [17:0] scale_phase_ma(input logic [11:0] code);
		int t;
		t = int'(code) * `I_SPAN_MA / `ADC_FS - `I_OFS_MA;
		return 18'(t);
	endfunction

	// magnitude above current limit
	function automatic logic over_current(input logic signed [17:0] ma);
		return (ma > 18'sd`OC_LIMIT_MA) || (ma < -18'sd`OC_LIMIT_MA);
	endfunction

	// compare level from m = v / e, centred on half carrier
	function automatic logic [15:0] modulate(input logic signed [15:0] v,
			input logic signed [17:0] e);
		int m;
		if (e <= 18'sd0) begin
			m = int'(HALF) / 2;
		end else begin
			m = int'(HALF) / 2 + int'(v) * int'(HALF) / int'(e);
		end
		if (m < 0) m = 0;
		if (m > int'(HALF)) m = int'(HALF);
		return 16'(m);
	endfunction

	// hardware overcurrent pin synchroniser
	logic hw_oc_meta_r, hw_oc_sync_r;
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hw_oc_meta_r <= 1'b1;
			hw_oc_sync_r <= 1'b1;
		end else begin
			hw_oc_meta_r <= hw_overcurrent_n_i;
			hw_oc_sync_r <= hw_oc_meta_r;
		end
	end

	// carrier and compare
	cmp_t cmp_r, cmp_nxt;
	logic ctrl_tick;
	logic [2:0] phase_on;

	pwm_triangle_gen #(
		.HALF(HALF)
	) u_carrier (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.cmp_i(cmp_r),
		.carrier_o(),
		.ctrl_tick_o(ctrl_tick),
		.phase_on_o(phase_on)
	);

	// measured values, scaled combinationally
	logic signed [17:0] bus_dv, cur_u, cur_v, cur_w;
	assign bus_dv = scale_bus_dv(adc_i.bus_voltage_channel);
	assign cur_u = scale_phase_ma(adc_i.phase_u_current_channel);
	assign cur_v = scale_phase_ma(adc_i.phase_v_current_channel);
	assign cur_w = scale_phase_ma(adc_i.phase_w_current_channel);

	// sampled values held per control period
	logic signed [17:0] bus_dv_r, bus_dv_nxt;
	logic [2:0][17:0] cur_r, cur_nxt;
	logic [15:0] spd_r, spd_nxt;

	// sample and compute compares once per control period
	always_comb begin
		bus_dv_nxt = bus_dv_r;
		cur_nxt = cur_r;
		spd_nxt = spd_r;
		cmp_nxt = cmp_r;
		if (ctrl_tick) begin
			bus_dv_nxt = bus_dv;
			cur_nxt = {cur_w, cur_v, cur_u};
			spd_nxt = speed_elec_i;
			cmp_nxt[0] = modulate(vcmd_i.u, bus_dv);
			cmp_nxt[1] = modulate(vcmd_i.v, bus_dv);
			cmp_nxt[2] = modulate(vcmd_i.w, bus_dv);
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_dv_r <= 18'sd0;
			cur_r <= '0;
			spd_r <= 16'h0000;
			cmp_r <= '0;
		end else begin
			bus_dv_r <= bus_dv_nxt;
			cur_r <= cur_nxt;
			spd_r <= spd_nxt;
			cmp_r <= cmp_nxt;
		end
	end

	// software writable registers
	logic [1:0] opcmd_r, opcmd_nxt;
	logic [15:0] speed_cmd_r, speed_cmd_nxt;
	logic [`FLT_W-1:0] irq_mask_r, irq_mask_nxt;

	always_comb begin
		opcmd_nxt = opcmd_r;
		speed_cmd_nxt = speed_cmd_r;
		irq_mask_nxt = irq_mask_r;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`REG_OPCMD: opcmd_nxt = reg_wdata_i[1:0];
				`REG_SPEED_CMD: speed_cmd_nxt = reg_wdata_i[15:0];
				`REG_IRQ_MASK: irq_mask_nxt = reg_wdata_i[`FLT_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			opcmd_r <= `RST_OPCMD;
			speed_cmd_r <= `RST_SPEED;
			irq_mask_r <= `RST_MASK;
		end else begin
			opcmd_r <= opcmd_nxt;
			speed_cmd_r <= speed_cmd_nxt;
			irq_mask_r <= irq_mask_nxt;
		end
	end

	// run state, fault latching and interrupt status
	run_state_e state_r, state_nxt;
	logic [1:0] seen_r, seen_nxt;
	logic hw_trip_r, hw_trip_nxt;
	logic [`FLT_W-1:0] irq_stat_r, irq_stat_nxt;
	logic [`FLT_W-1:0] fault_now;
	logic hw_active;

	assign hw_active = ~hw_oc_sync_r;

	always_comb begin
		state_nxt = state_r;
		seen_nxt = seen_r;
		hw_trip_nxt = hw_trip_r;
		irq_stat_nxt = irq_stat_r;
		fault_now = '0;
		// periodic software checks on fresh samples
		if (ctrl_tick) begin
			fault_now[`FLT_SW_OC] = over_current(cur_u) | over_current(cur_v)
				| over_current(cur_w);
			fault_now[`FLT_OV] = bus_dv > 18'sd`OV_LIMIT_DV;
			fault_now[`FLT_UV] = bus_dv < 18'sd`UV_LIMIT_DV;
			fault_now[`FLT_OSPD] = speed_elec_i > 16'd`OSPD_LIMIT_RADS;
		end
		fault_now[`FLT_HW_OC] = hw_active;
		// command acted on only when it changes
		if (opcmd_r != seen_r) begin
			seen_nxt = opcmd_r;
			unique case (opcmd_r)
				`OPCMD_RUN: if (state_r == ST_STOP) state_nxt = ST_RUN;
				`OPCMD_STOP: if (state_r == ST_RUN) state_nxt = ST_STOP;
				`OPCMD_ERR_RST: begin
					if (state_r == ST_ERROR) state_nxt = ST_STOP;
					hw_trip_nxt = 1'b0;
				end
				default: ;
			endcase
		end
		// any fault latches the error state, winning over a reset
		if (|fault_now) begin
			state_nxt = ST_ERROR;
		end
		if (hw_active) begin
			hw_trip_nxt = 1'b1;
		end
		// write one to clear, a new event wins
		if (reg_wr_i && reg_addr_i == `REG_IRQ_STAT) begin
			irq_stat_nxt = irq_stat_nxt & ~reg_wdata_i[`FLT_W-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | fault_now;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= ST_STOP;
			seen_r <= `RST_OPCMD;
			hw_trip_r <= 1'b0;
			irq_stat_r <= '0;
		end else begin
			state_r <= state_nxt;
			seen_r <= seen_nxt;
			hw_trip_r <= hw_trip_nxt;
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// gate drives and enables
	gate_s gate_r, gate_nxt;
	logic [5:0] oe_r, oe_nxt;

	always_comb begin
		gate_nxt = '0;
		if (state_r == ST_RUN && state_nxt == ST_RUN) begin
			gate_nxt.hi = phase_on;
			gate_nxt.lo = ~phase_on;
		end
		// float all pins while the hardware trip holds
		oe_nxt = (hw_trip_r | hw_active) ? 6'h00 : 6'h3f;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gate_r <= '0;
			oe_r <= 6'h3f;
		end else begin
			gate_r <= gate_nxt;
			oe_r <= oe_nxt;
		end
	end

	// read data, one cycle after the strobe
	logic [31:0] rdata_r, rdata_nxt;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`REG_OPCMD: rdata_nxt[1:0] = opcmd_r;
				`REG_SPEED_CMD: rdata_nxt[15:0] = speed_cmd_r;
				`REG_STATUS: begin
					rdata_nxt[`STAT_STATE_LSB +: 3] = state_r;
					rdata_nxt[`STAT_HWTRIP] = hw_trip_r;
					rdata_nxt[`STAT_OPCMD_LSB +: 2] = seen_r;
				end
				`REG_IRQ_STAT: rdata_nxt[`FLT_W-1:0] = irq_stat_r;
				`REG_IRQ_MASK: rdata_nxt[`FLT_W-1:0] = irq_mask_r;
				`REG_BUS_VOLT: rdata_nxt = 32'(bus_dv_r);
				`REG_CUR_U: rdata_nxt = 32'(signed'(cur_r[0]));
				`REG_CUR_V: rdata_nxt = 32'(signed'(cur_r[1]));
				`REG_CUR_W: rdata_nxt = 32'(signed'(cur_r[2]));
				`REG_SPEED_MEAS: rdata_nxt[15:0] = spd_r;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// outputs
	assign reg_rdata_o = rdata_r;
	assign speed_command_rpm_o = speed_cmd_r;
	assign running_o = state_r == ST_RUN;
	assign gate_o = gate_r;
	assign gate_oe_o = oe_r;
	assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule // motor_pwm_fault_supervisor

// >>> test/motor_pwm_fault_supervisor_chk.sv
// port checker for the fan motor pwm supervisor
`timescale 1ns/1ps
module motor_pwm_fault_supervisor_chk #(
	parameter int unsigned CTRL_CYCLES = 5000
) (
	input wire logic core_clk_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic [7:0] reg_addr_i, // address
	input wire logic [31:0] reg_wdata_i, // write data
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	input wire logic [31:0] reg_rdata_o, // read data
	input wire fan_supervisor_pkg::adc_sample_s adc_i, // codes
	input wire fan_supervisor_pkg::phase_vcmd_s vcmd_i, // commands
	input wire logic [15:0] speed_elec_i, // speed
	input wire logic hw_overcurrent_n_i, // trip pin
	input wire logic [15:0] speed_command_rpm_o, // speed ref
	input wire logic running_o, // run state
	input wire fan_supervisor_pkg::gate_s gate_o, // gates
	input wire logic [5:0] gate_oe_o, // enables
	input wire logic irq_o // interrupt
);
	import fan_supervisor_pkg::*;
	logic [15:0] wlo;
	logic [1:0] op;
	logic flt;
	logic [7:0] flt_cnt_r;
	logic [7:0] flt_cnt_nxt;
	// data slices and run length of a faulty input
	assign wlo = reg_wdata_i[15:0];
	assign op = reg_wdata_i[1:0];
	assign flt = (speed_elec_i > 16'h0110) || (adc_i.bus_voltage_channel >= 12'h9ca);
	always_comb begin
		flt_cnt_nxt = flt_cnt_r;
		if (!flt)
			flt_cnt_nxt = 8'h00;
		else if (flt_cnt_r != 8'hff)
			flt_cnt_nxt = flt_cnt_r + 8'h01;
	end
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			flt_cnt_r <= 8'h00;
		else
			flt_cnt_r <= flt_cnt_nxt;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// bus, command and protection relations
	property p_rd_idle;
		!reg_rd_i |=> reg_rdata_o == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_speed_cmd;
		reg_wr_i && reg_addr_i == 8'h04 |=> speed_command_rpm_o == $past(wlo);
	endproperty
	a_speed_cmd: assert property (p_speed_cmd) else $error("speed ref lost");
	property p_run_cause;
		$rose(running_o) |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 8'h00
			&& $past(op, 2) == 2'h1;
	endproperty
	a_run_cause: assert property (p_run_cause) else $error("run without command");
	property p_stop_cmd;
		reg_wr_i && reg_addr_i == 8'h00 && op == 2'h0 |=> ##1 !running_o;
	endproperty
	a_stop_cmd: assert property (p_stop_cmd) else $error("stop ignored");
	property p_gate_idle;
		!running_o [*2] |-> gate_o == 6'h00;
	endproperty
	a_gate_idle: assert property (p_gate_idle) else $error("gates active");
	property p_gate_pair;
		running_o [*2] |-> gate_o.lo == ~gate_o.hi;
	endproperty
	a_gate_pair: assert property (p_gate_pair) else $error("gate pair wrong");
	property p_hw_float;
		!hw_overcurrent_n_i [*4] |-> gate_oe_o == 6'h00;
	endproperty
	a_hw_float: assert property (p_hw_float) else $error("pins still driven");
	property p_oe_cause;
		$fell(gate_oe_o == 6'h3f) |-> $past(hw_overcurrent_n_i, 3) == 1'b0;
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pins floated early");
	property p_flt_stop;
		flt_cnt_r > CTRL_CYCLES + 3 |-> !running_o;
	endproperty
	a_flt_stop: assert property (p_flt_stop) else $error("fault not stopped");
endmodule // motor_pwm_fault_supervisor_chk

bind motor_pwm_fault_supervisor motor_pwm_fault_supervisor_chk #(
	.CTRL_CYCLES(CTRL_CYCLES)
) chk_i (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .adc_i(adc_i), .vcmd_i(vcmd_i), .speed_elec_i(speed_elec_i),
	.hw_overcurrent_n_i(hw_overcurrent_n_i), .speed_command_rpm_o(speed_command_rpm_o),
	.running_o(running_o), .gate_o(gate_o), .gate_oe_o(gate_oe_o), .irq_o(irq_o)
);

// >>> test/inverter_stage_model.sv
// behavioural inverter stage: sensed codes, speed, trip pin
`timescale 1ns/1ps
module inverter_stage_model (
	input wire logic core_clk_i, // clock
	input wire fan_supervisor_pkg::gate_s gate_i, // gate levels
	input wire logic [5:0] gate_oe_i, // gate enables
	input wire logic [11:0] bus_code_i, // bus code
	input wire logic [11:0] cur_code_i, // u code when driven
	input wire logic [15:0] spd_i, // speed
	input wire logic trip_n_i, // trip request
	output fan_supervisor_pkg::adc_sample_s adc_o, // sensed codes
	output logic [15:0] speed_o, // rotor speed
	output logic hw_n_o // overcurrent pin
);
	import fan_supervisor_pkg::*;
	logic drv;
	// current flows only while a gate is driven on
	assign drv = |(gate_i & gate_oe_i);
	// converter codes refresh every clock, settled long before reset ends
	always @(posedge core_clk_i) begin
		adc_o.bus_voltage_channel <= bus_code_i;
		adc_o.phase_u_current_channel <= drv ? cur_code_i : 12'h800;
		adc_o.phase_v_current_channel <= 12'h800;
		adc_o.phase_w_current_channel <= 12'h800;
		speed_o <= spd_i;
		hw_n_o <= trip_n_i;
	end
endmodule // inverter_stage_model

// >>> test/motor_pwm_fault_supervisor_tb.sv
// self-checking bench for the fan motor pwm supervisor
`timescale 1ns/1ps
module motor_pwm_fault_supervisor_tb;
	import fan_supervisor_pkg::*;
	localparam int unsigned CYC = 40;
	logic core_clk_i;
	logic sys_rst_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [31:0] reg_rdata_o;
	adc_sample_s adc_i;
	phase_vcmd_s vcmd_i;
	logic [15:0] speed_elec_i;
	logic hw_overcurrent_n_i;
	logic [15:0] speed_command_rpm_o;
	logic running_o;
	gate_s gate_o;
	logic [5:0] gate_oe_o;
	logic irq_o;
	logic [11:0] bus_code;
	logic [11:0] cur_code;
	logic [15:0] spd;
	logic trip_n;
	logic rd_d = 1'b0;
	logic [15:0] sc;
	logic [31:0] cu, cv, cw;
	logic [31:0] exp_q[$];
	int bits[4] = '{0, 0, 1, 3};
	int mismatches;
	int checks_done;
	motor_pwm_fault_supervisor #(.CTRL_CYCLES(CYC)) motor_pwm_fault_supervisor_i (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .adc_i(adc_i), .vcmd_i(vcmd_i), .speed_elec_i(speed_elec_i),
		.hw_overcurrent_n_i(hw_overcurrent_n_i), .speed_command_rpm_o(speed_command_rpm_o),
		.running_o(running_o), .gate_o(gate_o), .gate_oe_o(gate_oe_o), .irq_o(irq_o)
	);
	inverter_stage_model inverter_stage_model_i (
		.core_clk_i(core_clk_i), .gate_i(gate_o), .gate_oe_i(gate_oe_o), .bus_code_i(bus_code),
		.cur_code_i(cur_code), .spd_i(spd), .trip_n_i(trip_n), .adc_o(adc_i),
		.speed_o(speed_elec_i), .hw_n_o(hw_overcurrent_n_i)
	);
	// clock and hang guard
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		mismatches++;
		give_verdict();
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: saw %h wanted %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// bus cycles; reads note their expected data
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		exp_q.push_back(want);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
	endtask
	task automatic op(input logic [31:0] v);
		wr(8'h00, v);
		repeat (3) @(posedge core_clk_i);
	endtask
	task automatic set_in(input int k, input logic bad);
		case (k)
			0: cur_code <= bad ? 12'h87b : 12'h87a;
			1: cur_code <= bad ? 12'h784 : 12'h785;
			2: bus_code <= bad ? 12'h9ca : 12'h9c9;
			default: spd <= bad ? 16'h0111 : 16'h0110;
		endcase
	endtask
	// read data compared in the cycle after the strobe
	always @(posedge core_clk_i) begin
		if (rd_d)
			check(reg_rdata_o, exp_q.pop_front());
		rd_d <= reg_rd_i;
	end
	initial begin
		sys_rst_i = 1'b1;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		vcmd_i = '0;
		bus_code = 12'h800;
		cur_code = 12'h800;
		spd = 16'h0064;
		trip_n = 1'b1;
		void'($urandom(37));
		repeat (5) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		wr(8'h08, 32'hffffffff);
		wr(8'h28, 32'hffffffff);
		rd(8'h08, 32'h1);
		rd(8'h28, 32'h0);
		sc = 16'($urandom);
		wr(8'h04, {16'h0, sc});
		rd(8'h04, {16'h0, sc});
		check({16'h0, speed_command_rpm_o}, {16'h0, sc});
		// run with clamped and mid-level phase commands
		wr(8'h10, 32'h1f);
		vcmd_i <= {16'h8000, 16'h7fff, 16'h0000};
		op(32'h1);
		rd(8'h08, 32'h102);
		repeat (CYC * 2) @(posedge core_clk_i);
		{cu, cv, cw} = '0;
		repeat (CYC) begin
			@(negedge core_clk_i);
			cu += gate_o.hi[0];
			cv += gate_o.hi[1];
			cw += gate_o.hi[2];
		end
		check(cu, 32'h0);
		// v clamps at the carrier peak, w sits at half: 19 and 9 of 20 per carrier
		check(cv, 32'h26);
		check(cw, 32'h12);
		// code 800 reads back as 343.3 V, 12 mA and the sampled speed
		rd(8'h14, 32'hd69);
		rd(8'h1c, 32'hc);
		rd(8'h24, 32'h64);
		op(32'h1);
		rd(8'h08, 32'h102);
		op(32'h0);
		rd(8'h08, 32'h1);
		// overcurrent both ways, overvoltage and overspeed, each at its boundary
		for (int k = 0; k < 4; k++) begin
			op(32'h1);
			vcmd_i <= {16'($urandom_range(200)), 32'h0};
			set_in(k, 1'b0);
			repeat (CYC * 2) @(posedge core_clk_i);
			rd(8'h08, 32'h102);
			set_in(k, 1'b1);
			repeat (CYC * 2) @(posedge core_clk_i);
			rd(8'h08, 32'h104);
			rd(8'h0c, 32'h1 << bits[k]);
			@(negedge core_clk_i);
			check({31'h0, irq_o}, 32'h1);
			check({26'h0, gate_o}, 32'h0);
			op(32'h0);
			op(32'h1);
			rd(8'h08, 32'h104);
			cur_code <= 12'h800;
			bus_code <= 12'h800;
			spd <= 16'h0064;
			wr(8'h0c, 32'h1f);
			rd(8'h0c, 32'h0);
			op(32'h3);
			rd(8'h08, 32'h301);
		end
		// external trip with its interrupt masked first
		op(32'h1);
		wr(8'h10, 32'h0f);
		trip_n <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		@(negedge core_clk_i);
		check({26'h0, gate_oe_o}, 32'h0);
		check({31'h0, irq_o}, 32'h0);
		rd(8'h08, 32'h114);
		rd(8'h0c, 32'h10);
		wr(8'h10, 32'h1f);
		@(negedge core_clk_i);
		check({31'h0, irq_o}, 32'h1);
		trip_n <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		wr(8'h0c, 32'h1f);
		op(32'h3);
		rd(8'h08, 32'h301);
		@(negedge core_clk_i);
		check({26'h0, gate_oe_o}, 32'h3f);
		check({31'h0, irq_o}, 32'h0);
		repeat (4) @(posedge core_clk_i);
		give_verdict();
	end
endmodule // motor_pwm_fault_supervisor_tb
